/* rtl/wake_cfg_pkg.sv */
// constants and types shared by the wake source and interrupt pin configuration block
package wake_cfg_pkg;

	// ==========================================================
	// register map: each entry is an index, byte address = index * 4
	localparam logic [7:0]  CFG_IDX        = 8'h2c;
	localparam logic [7:0]  SYS_IDX        = 8'h0b;
	localparam logic [7:0]  IRQ_STAT_IDX   = 8'h40;
	localparam logic [7:0]  IRQ_MASK_IDX   = 8'h41;
	localparam logic [21:0] ADDR_HI_ZERO   = 22'h000000;
	localparam logic [1:0]  ADDR_LO_ZERO   = 2'h0;

	// ==========================================================
	// configuration register layout
	localparam logic [7:0]  CFG_RESET      = 8'h00;
	localparam logic [7:0]  CFG_WR_MASK    = 8'hfb;

	typedef struct packed {
		logic fifo_hold;
		logic transient_wake_enable;
		logic orientation_wake_enable;
		logic pulse_wake_enable;
		logic fall_motion_wake_enable;
		logic reserved;
		logic irq_polarity;
		logic irq_drive_type;
	} cfg_t;

	// detection function interrupts, same order as the wake enables
	typedef struct packed {
		logic transient;
		logic orientation;
		logic pulse;
		logic fall_motion;
	} detect_t;

	// ==========================================================
	// system mode status layout
	localparam int          SYS_SLEEP_BIT  = 0;
	localparam int          SYS_PIN1_BIT   = 2;
	localparam int          SYS_PIN2_BIT   = 3;
	localparam int          SYS_ERR_BIT    = 7;

	// ==========================================================
	// interrupt status and mask layout
	localparam int          IRQ_W          = 2;
	localparam int          IRQ_ERR_BIT    = 0;
	localparam int          IRQ_WAKE_BIT   = 1;
	localparam logic [1:0]  IRQ_RESET      = 2'h0;

	// ==========================================================
	// bus and pins
	localparam logic        RESP_OKAY      = 1'b0;
	localparam logic [31:0] RDATA_ZERO     = 32'h00000000;
	localparam logic        PIN_O_RESET    = 1'b1;
	localparam logic        PIN_OE_RESET   = 1'b1;
	localparam int          NUM_PINS       = 2;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_READ = 1'b1
	} bus_state_t;

endpackage : wake_cfg_pkg

/* rtl/irq_pin_driver.sv */
// one interrupt pad: polarity and push-pull or open-drain drive
`timescale 1ns/1ps
`default_nettype none

module irq_pin_driver (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// request and settings
	input  wire logic req,
	input  wire logic polarity,
	input  wire logic open_drain,
	// pad
	output var  logic pin_o_q,
	output var  logic pin_oe_q
);

	logic level;

	// ==========================================================
	// drive
	assign level = polarity ? req : ~req;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_o_q  <= wake_cfg_pkg::PIN_O_RESET;
			pin_oe_q <= wake_cfg_pkg::PIN_OE_RESET;
		end
		else if (open_drain)
		begin
			// released high level relies on the shared line's pull-up
			pin_o_q  <= 1'b0;
			pin_oe_q <= ~level;
		end
		else
		begin
			pin_o_q  <= level;
			pin_oe_q <= 1'b1;
		end
	end

	// ==========================================================
	// checks
	property p_pp_level;
		@(posedge clk) disable iff (rst)
		!open_drain |=> (pin_oe_q && pin_o_q == ($past(req) ~^ $past(polarity)));
	endproperty
	a_pp_level: assert property (p_pp_level) else $error("push-pull level wrong");

	property p_od_drive;
		@(posedge clk) disable iff (rst)
		open_drain |=> (!pin_o_q && pin_oe_q == !($past(req) ~^ $past(polarity)));
	endproperty
	a_od_drive: assert property (p_od_drive) else $error("open-drain drive wrong");

endmodule : irq_pin_driver

`default_nettype wire

/* rtl/wake_irq_cfg.sv */
// wake source, fifo hold and interrupt pin configuration block with ahb-lite slave
//
// How it works
// - hold off: mode change flushes whole fifo
// - hold on: mode change blocks input until empty
// - sample during hold before empty sets error
// - error stays until fifo emptied, then clears
// - transient wake enable, else bypassed in sleep
// - orientation wake enable, else bypassed in sleep
// - pulse wake enable, else bypassed in sleep
// - fall/motion wake enable, else bypassed in sleep
// - polarity bit: 0 active low, 1 high
// - drive bit: 0 push-pull, 1 open-drain
// - polarity and drive apply to both pins
// - config register read/write at index 2c
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module wake_irq_cfg (
	// clock and reset
	input  wire logic                    CLK,
	input  wire logic                    SYS_RST,
	// ahb-lite slave
	input  wire logic                    HSEL,
	input  wire logic [31:0]             HADDR,
	input  wire logic [1:0]              HTRANS,
	input  wire logic                    HWRITE,
	input  wire logic [2:0]              HSIZE,
	input  wire logic [31:0]             HWDATA,
	input  wire logic                    HREADY,
	output var  logic [31:0]             HRDATA,
	output var  logic                    HREADYOUT,
	output var  logic                    HRESP,
	// system mode and fifo
	input  wire logic                    SLEEP_MODE,
	input  wire logic                    SAMPLE_STROBE,
	input  wire logic                    FIFO_EMPTY,
	output var  logic                    FIFO_FLUSH,
	output var  logic                    FIFO_INPUT_BLOCK,
	// detection functions and wake
	input  wire wake_cfg_pkg::detect_t   DETECT_IRQ,
	output var  logic [3:0]              DETECT_BYPASS,
	output var  logic                    WAKE_REQUEST,
	// interrupt pins
	input  wire logic                    IRQ_ONE_REQ,
	input  wire logic                    IRQ_TWO_REQ,
	input  wire logic                    IRQ_PIN_ONE_I,
	output var  logic                    IRQ_PIN_ONE_O,
	output var  logic                    IRQ_PIN_ONE_OE,
	input  wire logic                    IRQ_PIN_TWO_I,
	output var  logic                    IRQ_PIN_TWO_O,
	output var  logic                    IRQ_PIN_TWO_OE,
	// block interrupt
	output var  logic                    IRQ
);

	// ==========================================================
	// declarations
	wake_cfg_pkg::cfg_t                  cfg_q;
	wake_cfg_pkg::bus_state_t            bus_q;
	logic [31:0]                         wr_addr_q;
	logic [31:0]                         rd_addr_q;
	logic                                wr_pend_q;
	logic [31:0]                         hrdata_q;
	logic                                hreadyout_q;
	logic [31:0]                         rdata;
	logic                                accept;
	logic                                sleep_q;
	logic                                mode_chg;
	logic                                gate_q;
	logic                                err_q;
	logic                                err_d;
	logic                                flush_q;
	logic                                wake_q;
	logic                                wake_d;
	logic [3:0]                          bypass_q;
	logic [3:0]                          wake_en;
	logic [wake_cfg_pkg::IRQ_W-1:0]      irq_stat_q;
	logic [wake_cfg_pkg::IRQ_W-1:0]      irq_stat_d;
	logic [wake_cfg_pkg::IRQ_W-1:0]      irq_mask_q;
	logic [wake_cfg_pkg::IRQ_W-1:0]      irq_set;
	logic                                irq_q;
	logic [1:0]                          pin_one_s_q;
	logic [1:0]                          pin_two_s_q;
	logic [wake_cfg_pkg::NUM_PINS-1:0]   pin_req;
	logic [wake_cfg_pkg::NUM_PINS-1:0]   pin_o;
	logic [wake_cfg_pkg::NUM_PINS-1:0]   pin_oe;

	function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
		reg_hit = (addr == {wake_cfg_pkg::ADDR_HI_ZERO, idx, wake_cfg_pkg::ADDR_LO_ZERO});
	endfunction : reg_hit

	// ==========================================================
	// bus phases: writes take no wait state, reads take one
	assign accept = HSEL && HREADY && HTRANS[1];

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= wake_cfg_pkg::RDATA_ZERO;
		end
		else
		begin
			wr_pend_q <= accept && HWRITE;
			if (accept && HWRITE)
			begin
				wr_addr_q <= HADDR;
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			bus_q       <= wake_cfg_pkg::BUS_IDLE;
			rd_addr_q   <= wake_cfg_pkg::RDATA_ZERO;
			hreadyout_q <= 1'b1;
			hrdata_q    <= wake_cfg_pkg::RDATA_ZERO;
		end
		else
		begin
			case (bus_q)
				wake_cfg_pkg::BUS_IDLE:
				begin
					if (accept && !HWRITE)
					begin
						bus_q       <= wake_cfg_pkg::BUS_READ;
						rd_addr_q   <= HADDR;
						hreadyout_q <= 1'b0;
					end
				end
				wake_cfg_pkg::BUS_READ:
				begin
					// sampled a cycle late so a preceding write is already visible
					bus_q       <= wake_cfg_pkg::BUS_IDLE;
					hrdata_q    <= rdata;
					hreadyout_q <= 1'b1;
				end
				default:
				begin
					bus_q       <= wake_cfg_pkg::BUS_IDLE;
					hreadyout_q <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		rdata = wake_cfg_pkg::RDATA_ZERO;
		if (reg_hit(rd_addr_q, wake_cfg_pkg::CFG_IDX))
		begin
			rdata[7:0] = cfg_q;
		end
		else if (reg_hit(rd_addr_q, wake_cfg_pkg::SYS_IDX))
		begin
			rdata[wake_cfg_pkg::SYS_SLEEP_BIT] = sleep_q;
			rdata[wake_cfg_pkg::SYS_PIN1_BIT]  = pin_one_s_q[1];
			rdata[wake_cfg_pkg::SYS_PIN2_BIT]  = pin_two_s_q[1];
			rdata[wake_cfg_pkg::SYS_ERR_BIT]   = err_q;
		end
		else if (reg_hit(rd_addr_q, wake_cfg_pkg::IRQ_STAT_IDX))
		begin
			rdata[wake_cfg_pkg::IRQ_W-1:0] = irq_stat_q;
		end
		else if (reg_hit(rd_addr_q, wake_cfg_pkg::IRQ_MASK_IDX))
		begin
			rdata[wake_cfg_pkg::IRQ_W-1:0] = irq_mask_q;
		end
	end

	// ==========================================================
	// configuration register
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			cfg_q <= wake_cfg_pkg::CFG_RESET;
		end
		else if (wr_pend_q && reg_hit(wr_addr_q, wake_cfg_pkg::CFG_IDX))
		begin
			cfg_q <= HWDATA[7:0] & wake_cfg_pkg::CFG_WR_MASK;
		end
	end

	// ==========================================================
	// fifo hold on wake/sleep change
	assign mode_chg = SLEEP_MODE != sleep_q;

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			sleep_q <= 1'b0;
			flush_q <= 1'b0;
		end
		else
		begin
			sleep_q <= SLEEP_MODE;
			flush_q <= mode_chg && !cfg_q.fifo_hold;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			gate_q <= 1'b0;
		end
		else if (mode_chg && cfg_q.fifo_hold)
		begin
			gate_q <= 1'b1;
		end
		else if (FIFO_EMPTY)
		begin
			gate_q <= 1'b0;
		end
	end

	// a sample in a cycle with the fifo empty does not set the error; the empty clears it
	assign err_d = (gate_q && SAMPLE_STROBE && !FIFO_EMPTY) ? 1'b1 :
		(FIFO_EMPTY ? 1'b0 : err_q);

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			err_q <= 1'b0;
		end
		else
		begin
			err_q <= err_d;
		end
	end

	// ==========================================================
	// wake sources
	assign wake_en = {cfg_q.transient_wake_enable, cfg_q.orientation_wake_enable,
		cfg_q.pulse_wake_enable, cfg_q.fall_motion_wake_enable};
	assign wake_d = SLEEP_MODE && |(wake_en & DETECT_IRQ);

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			wake_q   <= 1'b0;
			bypass_q <= 4'h0;
		end
		else
		begin
			wake_q   <= wake_d;
			bypass_q <= {4{SLEEP_MODE}} & ~wake_en;
		end
	end

	// ==========================================================
	// interrupt status, mask and output
	assign irq_set[wake_cfg_pkg::IRQ_ERR_BIT]  = err_d && !err_q;
	assign irq_set[wake_cfg_pkg::IRQ_WAKE_BIT] = wake_d && !wake_q;

	always_comb
	begin
		irq_stat_d = irq_stat_q;
		if (wr_pend_q && reg_hit(wr_addr_q, wake_cfg_pkg::IRQ_STAT_IDX))
		begin
			irq_stat_d = irq_stat_q & ~HWDATA[wake_cfg_pkg::IRQ_W-1:0];
		end
		// set beats a clear in the same cycle
		irq_stat_d = irq_stat_d | irq_set;
	end

	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			irq_stat_q <= wake_cfg_pkg::IRQ_RESET;
			irq_mask_q <= wake_cfg_pkg::IRQ_RESET;
			irq_q      <= 1'b0;
		end
		else
		begin
			irq_stat_q <= irq_stat_d;
			if (wr_pend_q && reg_hit(wr_addr_q, wake_cfg_pkg::IRQ_MASK_IDX))
			begin
				irq_mask_q <= HWDATA[wake_cfg_pkg::IRQ_W-1:0];
			end
			irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	// ==========================================================
	// interrupt pads
	always_ff @(posedge CLK)
	begin
		if (SYS_RST)
		begin
			pin_one_s_q <= 2'h0;
			pin_two_s_q <= 2'h0;
		end
		else
		begin
			pin_one_s_q <= {pin_one_s_q[0], IRQ_PIN_ONE_I};
			pin_two_s_q <= {pin_two_s_q[0], IRQ_PIN_TWO_I};
		end
	end

	assign pin_req = {IRQ_TWO_REQ, IRQ_ONE_REQ};

	generate
		for (genvar i = 0; i < wake_cfg_pkg::NUM_PINS; i++)
		begin : g_pin
			irq_pin_driver u_drv (
				.clk        (CLK),
				.rst        (SYS_RST),
				.req        (pin_req[i]),
				.polarity   (cfg_q.irq_polarity),
				.open_drain (cfg_q.irq_drive_type),
				.pin_o_q    (pin_o[i]),
				.pin_oe_q   (pin_oe[i])
			);
		end
	endgenerate

	// ==========================================================
	// outputs
	assign HRDATA           = hrdata_q;
	assign HREADYOUT        = hreadyout_q;
	assign HRESP            = wake_cfg_pkg::RESP_OKAY;
	assign FIFO_FLUSH       = flush_q;
	assign FIFO_INPUT_BLOCK = gate_q;
	assign DETECT_BYPASS    = bypass_q;
	assign WAKE_REQUEST     = wake_q;
	assign IRQ_PIN_ONE_O    = pin_o[0];
	assign IRQ_PIN_ONE_OE   = pin_oe[0];
	assign IRQ_PIN_TWO_O    = pin_o[1];
	assign IRQ_PIN_TWO_OE   = pin_oe[1];
	assign IRQ              = irq_q;

	// ==========================================================
	// checks
	sequence s_hold_change;
		mode_chg && cfg_q.fifo_hold;
	endsequence

	sequence s_late_sample;
		FIFO_INPUT_BLOCK && SAMPLE_STROBE && !FIFO_EMPTY;
	endsequence

	property p_flush;
		@(posedge CLK) disable iff (SYS_RST)
		(mode_chg && !cfg_q.fifo_hold) |=> FIFO_FLUSH ##1 (FIFO_FLUSH == $past(mode_chg && !cfg_q.fifo_hold));
	endproperty
	a_flush: assert property (p_flush) else $error("no single flush on change");

	property p_hold;
		@(posedge CLK) disable iff (SYS_RST)
		s_hold_change |=> (FIFO_INPUT_BLOCK && !FIFO_FLUSH);
	endproperty
	a_hold: assert property (p_hold) else $error("hold did not block input");

	property p_err_set;
		@(posedge CLK) disable iff (SYS_RST)
		s_late_sample |=> err_q;
	endproperty
	a_err_set: assert property (p_err_set) else $error("hold error not raised");

	property p_err_life;
		@(posedge CLK) disable iff (SYS_RST)
		(err_q && !FIFO_EMPTY) |=> err_q;
	endproperty
	a_err_life: assert property (p_err_life) else $error("hold error dropped early");

	property p_err_clear;
		@(posedge CLK) disable iff (SYS_RST)
		FIFO_EMPTY |=> !err_q;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("hold error not cleared");

	property p_transient_wake_enable;
		@(posedge CLK) disable iff (SYS_RST)
		(SLEEP_MODE && cfg_q.transient_wake_enable && DETECT_IRQ.transient) |=> WAKE_REQUEST;
	endproperty
	a_transient_wake_enable: assert property (p_transient_wake_enable) else $error("transient wake missed");

	property p_bypass_orient;
		@(posedge CLK) disable iff (SYS_RST)
		(SLEEP_MODE && !cfg_q.orientation_wake_enable) |=> DETECT_BYPASS[2];
	endproperty
	a_bypass_orient: assert property (p_bypass_orient) else $error("orientation not bypassed");

	property p_wake_pulse;
		@(posedge CLK) disable iff (SYS_RST)
		(SLEEP_MODE && cfg_q.pulse_wake_enable && DETECT_IRQ.pulse) |=> WAKE_REQUEST;
	endproperty
	a_wake_pulse: assert property (p_wake_pulse) else $error("pulse wake missed");

	property p_no_wake_ffmt;
		@(posedge CLK) disable iff (SYS_RST)
		(SLEEP_MODE && DETECT_IRQ == 4'h1 && !cfg_q.fall_motion_wake_enable) |=> !WAKE_REQUEST;
	endproperty
	a_no_wake_ffmt: assert property (p_no_wake_ffmt) else $error("bypassed source woke");

	property p_cfg_write;
		@(posedge CLK) disable iff (SYS_RST)
		(wr_pend_q && reg_hit(wr_addr_q, wake_cfg_pkg::CFG_IDX))
			|=> (cfg_q == ($past(HWDATA[7:0]) & wake_cfg_pkg::CFG_WR_MASK));
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

	property p_reserved;
		@(posedge CLK) disable iff (SYS_RST)
		!cfg_q.reserved;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit set");

endmodule : wake_irq_cfg

`default_nettype wire

/* verification/irq_host_model.sv */
// host side model of the two interrupt lines, each with a pull-up
`timescale 1ns/1ps
`default_nettype none

module irq_host_model (
	// pads of the device
	input  wire logic [1:0] pin_o,
	input  wire logic [1:0] pin_oe,
	// resolved line levels seen by the host
	output var  logic [1:0] line
);
	// ==========================================================
	// line resolution
	// pull-up lets several open-drain sources share one line
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			line[i] = pin_oe[i] ? pin_o[i] : 1'b1;
		end
	end
endmodule : irq_host_model

`default_nettype wire

/* verification/tb_wake_irq_cfg.sv */
// self-checking bench for the wake source and interrupt pin configuration block
`timescale 1ns/1ps
`default_nettype none

module tb_wake_irq_cfg;
	// ==========================================================
	// signals
	logic                  clk;
	logic                  sys_rst = 1'b1;
	logic                  hwrite = 1'b0;
	logic [1:0]            htrans = 2'h0;
	logic [31:0]           haddr = 32'h0;
	logic [31:0]           hwdata = 32'h0;
	logic                  sleep_mode = 1'b0;
	logic                  strobe = 1'b0;
	logic                  fifo_empty = 1'b1;
	logic                  req_one = 1'b0;
	logic                  req_two = 1'b0;
	wake_cfg_pkg::detect_t detect = '0;
	logic [31:0]           hrdata;
	logic [31:0]           rd;
	logic                  hreadyout;
	logic                  hresp;
	logic                  flush;
	logic                  block;
	logic                  wake_req;
	logic                  irq;
	logic [3:0]            bypass;
	logic [1:0]            pin_o;
	logic [1:0]            pin_oe;
	logic [1:0]            line;
	int                    n_errors = 0;
	int                    num_checks = 0;

	wake_irq_cfg DUT (
		.CLK(clk),
		.SYS_RST(sys_rst),
		.HSEL(1'b1),
		.HADDR(haddr),
		.HTRANS(htrans),
		.HWRITE(hwrite),
		.HSIZE(3'h2),
		.HWDATA(hwdata),
		.HREADY(hreadyout),
		.HRDATA(hrdata),
		.HREADYOUT(hreadyout),
		.HRESP(hresp),
		.SLEEP_MODE(sleep_mode),
		.SAMPLE_STROBE(strobe),
		.FIFO_EMPTY(fifo_empty),
		.FIFO_FLUSH(flush),
		.FIFO_INPUT_BLOCK(block),
		.DETECT_IRQ(detect),
		.DETECT_BYPASS(bypass),
		.WAKE_REQUEST(wake_req),
		.IRQ_ONE_REQ(req_one),
		.IRQ_TWO_REQ(req_two),
		.IRQ_PIN_ONE_I(line[0]),
		.IRQ_PIN_ONE_O(pin_o[0]),
		.IRQ_PIN_ONE_OE(pin_oe[0]),
		.IRQ_PIN_TWO_I(line[1]),
		.IRQ_PIN_TWO_O(pin_o[1]),
		.IRQ_PIN_TWO_OE(pin_oe[1]),
		.IRQ(irq)
	);

	irq_host_model host (
		.pin_o(pin_o),
		.pin_oe(pin_oe),
		.line(line)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	// entered right after an edge; outputs are read at edges, before they update
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		@(posedge clk);
		while (!hreadyout)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (!hreadyout)
			@(posedge clk);
		rd = hrdata;
	endtask : bus

	task automatic finish_test;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test

	// ==========================================================
	// scenarios
	task automatic t_regs;
		bus(1'b0, 32'hb0, 32'h0);
		check(rd, 32'h0);
		check(hresp, 1'b0);
		check({pin_o, pin_oe}, 4'hf);
		bus(1'b1, 32'hb0, 32'hffffffff);
		bus(1'b0, 32'hb0, 32'h0);
		check(rd, 32'hfb);
		bus(1'b0, 32'h3fc, 32'h0);
		check(rd, 32'h0);
	endtask : t_regs

	task automatic t_pins;
		logic rq;
		logic lv;
		for (int p = 0; p < 4; p++)
		begin
			for (int r = 0; r < 2; r++)
			begin
				bus(1'b1, 32'hb0, 32'(p));
				req_one <= r[0];
				req_two <= !r[0];
				cyc(2);
				for (int k = 0; k < 2; k++)
				begin
					rq = (k == 1) ? !r[0] : r[0];
					lv = p[1] ? rq : !rq;
					check({pin_o[k], pin_oe[k]}, p[0] ? {1'b0, !lv} : {lv, 1'b1});
					check(line[k], lv);
				end
			end
		end
		// pad read-back through the synchronisers, sleep bit low
		bus(1'b0, 32'h2c, 32'h0);
		check(rd & 32'hd, {28'h0, line, 2'b00});
	endtask : t_pins

	task automatic t_wake;
		for (int i = 0; i < 4; i++)
		begin
			bus(1'b1, 32'hb0, 32'h08 << i);
			detect     <= wake_cfg_pkg::detect_t'(4'h1 << i);
			sleep_mode <= 1'b1;
			cyc(2);
			check(wake_req, 1'b1);
			check(bypass, 4'hf & ~(4'h1 << i));
			detect <= wake_cfg_pkg::detect_t'(~(4'h1 << i));
			cyc(2);
			check(wake_req, 1'b0);
		end
		sleep_mode <= 1'b0;
		cyc(2);
		check(bypass, 4'h0);
		bus(1'b0, 32'h100, 32'h0);
		check(rd & 32'h2, 32'h2);
		bus(1'b1, 32'h104, 32'h2);
		cyc(2);
		check(irq, 1'b1);
		bus(1'b1, 32'h100, 32'h2);
		cyc(2);
		check(irq, 1'b0);
	endtask : t_wake

	task automatic t_fifo;
		bus(1'b1, 32'hb0, 32'h0);
		sleep_mode <= 1'b1;
		cyc(2);
		check(flush, 1'b1);
		cyc(1);
		check(flush, 1'b0);
		check(block, 1'b0);
		bus(1'b1, 32'hb0, 32'h80);
		fifo_empty <= 1'b0;
		sleep_mode <= 1'b0;
		cyc(2);
		check(block, 1'b1);
		check(flush, 1'b0);
		strobe <= 1'b1;
		cyc(1);
		strobe <= 1'b0;
		bus(1'b0, 32'h2c, 32'h0);
		check(rd & 32'h81, 32'h80);
		bus(1'b1, 32'h104, 32'h1);
		cyc(2);
		check(irq, 1'b1);
		check(block, 1'b1);
		// host drains the fifo
		fifo_empty <= 1'b1;
		cyc(2);
		check(block, 1'b0);
		bus(1'b0, 32'h2c, 32'h0);
		check(rd & 32'h80, 32'h0);
		bus(1'b1, 32'h100, 32'h1);
		cyc(2);
		check(irq, 1'b0);
	endtask : t_fifo

	// ==========================================================
	// main sequence and watchdog
	initial
	begin
		cyc(2);
		sys_rst <= 1'b0;
		cyc(1);
		t_regs();
		t_pins();
		t_wake();
		t_fifo();
		finish_test();
	end

	// about a hundred cycles are expected; this is 5000 cycles, far beyond
	initial
	begin
		#50000;
		n_errors++;
		finish_test();
	end
endmodule : tb_wake_irq_cfg

`default_nettype wire
